/* File: core/dmd_decoder.sv */
// Data and program memory address decoder
// Functional notes
// - Upper 128 idata bytes: indirect goes to RAM, direct to SFR space.
// - SFR space is paged, up to 256 pages behind one direct window.
// - Lower 128 idata bytes map the same for direct and indirect.
// - First 32 idata bytes are four banks of working registers.
// - Next 16 bytes are reachable as bytes or as single bits.
// - On-chip-only mapping aliases the 4 kB RAM every 4 k across 64 k.
// - Three xdata mappings: on-chip only, off-chip only, or split.
// - Split mapping: below 4 k on-chip, 4 k and above off-chip.
// - Off-chip port uses shared or separate address/data lines.
// - Flash is reprogrammed in 512-byte sectors.
// - On 64 k flash parts 0xfc00 to 0xffff is reserved.
// - A separate 128-byte scratchpad sector holds firmware data.
`default_nettype none

module dmd_decoder
  import dmd_pkg::*;
#(
  parameter int XAW = XRAM_AW
)
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // Internal data access
  input  wire logic                  idata_req,
  input  wire logic [7:0]            idata_addr,
  input  wire logic                  idata_indirect,
  input  wire logic                  idata_bit,
  input  wire logic [7:0]            sfr_page,
  output logic                       idata_ack,
  output logic                       iram_sel,
  output logic                       sfr_sel,
  output logic [7:0]                 idata_index,
  output logic [7:0]                 sfr_page_out,
  output logic                       bank_hit,
  output logic [1:0]                 bank_num,
  output logic                       bit_hit,
  output logic [2:0]                 bit_pos,
  // External data access
  input  wire logic                  xdata_req,
  input  wire logic                  xdata_we,
  input  wire logic [XDATA_AW-1:0]   xdata_addr,
  input  wire logic [7:0]            xdata_wdata,
  input  wire logic [1:0]            map_mode,
  input  wire logic                  port_muxed,
  output logic                       xdata_ack,
  output logic                       xram_sel,
  output logic                       ext_sel,
  output logic [7:0]                 xram_rdata,
  output logic [XDATA_AW-1:0]        offchip_memory_port_addr,
  output logic                       offchip_memory_port_muxed,
  // Program space
  input  wire logic                  code_req,
  input  wire logic [15:0]           code_addr,
  input  wire logic                  code_scratch,
  input  wire logic                  flash_64k,
  output logic                       code_ack,
  output logic [15-SECTOR_AW:0]      flash_sector,
  output logic                       flash_reserved,
  output logic                       scratch_sel,
  output logic [SCRATCH_AW-1:0]      scratch_index
);

  // ----------------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------------
  // Off-chip when the mapping says so; unused encoding falls back off-chip
  function automatic logic goes_offchip(input logic [1:0] m,
                                        input logic [15:0] a);
    if (m == DMD_MAP_ONCHIP)
      return 1'b0;
    else if (m == DMD_MAP_SPLIT)
      return a >= XRAM_SPLIT_TOP;
    else
      return 1'b1;
  endfunction : goes_offchip

  function automatic logic is_upper(input logic [7:0] a);
    return a >= IDATA_UPPER_BASE;
  endfunction : is_upper

  // ----------------------------------------------------------------------
  // Internal data routing
  // ----------------------------------------------------------------------
  logic [7:0] byte_addr;

  // Bit addresses below the upper half land in the 16-byte bit area
  always_comb
  begin
    if (idata_bit && !is_upper(idata_addr))
      byte_addr = BIT_AREA_BASE + {4'h0, idata_addr[6:3]};
    else if (idata_bit)
      byte_addr = {idata_addr[7:3], 3'h0};
    else
      byte_addr = idata_addr;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      idata_ack    <= 1'b0;
      iram_sel     <= 1'b0;
      sfr_sel      <= 1'b0;
      idata_index  <= 8'h00;
      sfr_page_out <= 8'h00;
      bit_pos      <= 3'h0;
      bit_hit      <= 1'b0;
    end
    else
    begin
      idata_ack <= idata_req;
      if (idata_req)
      begin
        // Upper half is dual mapped; lower half ignores the mode
        sfr_sel  <= is_upper(byte_addr) && !idata_indirect;
        iram_sel <= !is_upper(byte_addr) || idata_indirect;
        idata_index  <= byte_addr;
        sfr_page_out <= sfr_page;
        bit_pos      <= idata_bit ? idata_addr[2:0] : 3'h0;
        bit_hit      <= idata_bit && !is_upper(idata_addr);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      bank_hit <= 1'b0;
      bank_num <= 2'h0;
    end
    else if (idata_req)
    begin
      bank_hit <= !idata_bit && byte_addr < BANK_AREA_END;
      bank_num <= byte_addr[BANK_SHIFT+1:BANK_SHIFT];
    end
  end

  // ----------------------------------------------------------------------
  // External data routing and expansion RAM
  // ----------------------------------------------------------------------
  logic xram_hit;
  assign xram_hit = xdata_req && !goes_offchip(map_mode, xdata_addr);

  dmd_xram #(
    .AW (XAW),
    .DW (8)
  ) u_xram (
    .clock (clock),
    .en    (xram_hit),
    .we    (xdata_we),
    .addr  (xdata_addr[XAW-1:0]),
    .wdata (xdata_wdata),
    .rdata (xram_rdata)
  );

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      xdata_ack                 <= 1'b0;
      xram_sel                  <= 1'b0;
      ext_sel                   <= 1'b0;
      offchip_memory_port_addr  <= 16'h0000;
      offchip_memory_port_muxed <= 1'b0;
    end
    else
    begin
      xdata_ack <= xdata_req;
      offchip_memory_port_muxed <= port_muxed;
      if (xdata_req)
      begin
        xram_sel <= xram_hit;
        ext_sel  <= !xram_hit;
        offchip_memory_port_addr <= xdata_addr;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Program flash and scratchpad
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      code_ack       <= 1'b0;
      flash_sector   <= '0;
      flash_reserved <= 1'b0;
      scratch_sel    <= 1'b0;
      scratch_index  <= '0;
    end
    else
    begin
      code_ack <= code_req;
      if (code_req)
      begin
        flash_sector   <= code_addr[15:SECTOR_AW];
        // Reserved area only exists on the full-size flash
        flash_reserved <= !code_scratch && flash_64k
                          && code_addr >= FLASH_RES_BASE;
        scratch_sel    <= code_scratch;
        scratch_index  <= code_addr[SCRATCH_AW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_direct_upper;
    idata_req && !idata_indirect && !idata_bit && idata_addr[7];
  endsequence

  sequence s_sfr_chosen;
    ##1 (sfr_sel && !iram_sel && idata_ack);
  endsequence

  property p_upper_direct;
    @(posedge clock) disable iff (!resetn)
    s_direct_upper |-> s_sfr_chosen;
  endproperty
  a_upper_direct: assert property (p_upper_direct)
    else $error("direct upper access not routed to sfr");

  property p_upper_indirect;
    @(posedge clock) disable iff (!resetn)
    idata_req && idata_indirect && !idata_bit |=> iram_sel && !sfr_sel;
  endproperty
  a_upper_indirect: assert property (p_upper_indirect)
    else $error("indirect access not routed to ram");

  property p_page;
    @(posedge clock) disable iff (!resetn)
    idata_req |=> sfr_page_out == $past(sfr_page);
  endproperty
  a_page: assert property (p_page)
    else $error("sfr page not carried");

  property p_bank;
    @(posedge clock) disable iff (!resetn)
    idata_req && !idata_bit && idata_addr < BANK_AREA_END
      |=> bank_hit && bank_num == $past(idata_addr[4:3]);
  endproperty
  a_bank: assert property (p_bank)
    else $error("register bank decode wrong");

  property p_bitarea;
    @(posedge clock) disable iff (!resetn)
    idata_req && idata_bit && !idata_addr[7] |=> bit_hit
      && idata_index >= BIT_AREA_BASE && idata_index < BIT_AREA_END;
  endproperty
  a_bitarea: assert property (p_bitarea)
    else $error("bit access outside bit area");

  property p_alias;
    @(posedge clock) disable iff (!resetn)
    xdata_req && map_mode == DMD_MAP_ONCHIP |=> xram_sel && !ext_sel;
  endproperty
  a_alias: assert property (p_alias)
    else $error("on-chip mapping left the expansion ram");

  property p_split;
    @(posedge clock) disable iff (!resetn)
    xdata_req && map_mode == DMD_MAP_SPLIT
      |=> ext_sel == ($past(xdata_addr) >= XRAM_SPLIT_TOP);
  endproperty
  a_split: assert property (p_split)
    else $error("split mapping boundary wrong");

  sequence s_port_follows;
    offchip_memory_port_muxed == $past(port_muxed);
  endsequence

  property p_offchip;
    @(posedge clock) disable iff (!resetn)
    xdata_req && map_mode == DMD_MAP_OFFCHIP
      |=> ext_sel && offchip_memory_port_addr == $past(xdata_addr)
      ##1 s_port_follows;
  endproperty
  a_offchip: assert property (p_offchip)
    else $error("off-chip mapping not honoured");

  property p_reserved;
    @(posedge clock) disable iff (!resetn)
    code_req && !code_scratch && flash_64k && code_addr >= FLASH_RES_BASE
      |=> flash_reserved && flash_sector == $past(code_addr[15:9]);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved flash not flagged");

endmodule : dmd_decoder

`default_nettype wire

/* File: core/dmd_xram.sv */
// On-chip expansion RAM with registered read data
`default_nettype none

module dmd_xram
  import dmd_pkg::*;
#(
  parameter int AW = XRAM_AW,
  parameter int DW = 8
)
(
  // Clock
  input  wire logic          clock,
  // Access
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output var  logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clock)
  begin
    if (en && we)
    begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (en && !we)
    begin
      rdata <= mem[addr];
    end
  end

endmodule : dmd_xram

`default_nettype wire

/* File: pkg/dmd_pkg.sv */
// Constants and types shared by the data memory address decoder
`default_nettype none

package dmd_pkg;

  // ----------------------------------------------------------------------
  // Internal data space
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDATA_UPPER_BASE = 8'h80;
  localparam logic [7:0] BANK_AREA_END    = 8'h20;
  localparam logic [7:0] BIT_AREA_END     = 8'h30;
  localparam logic [7:0] BIT_AREA_BASE    = 8'h20;
  localparam int         BANK_SHIFT       = 3;

  // ----------------------------------------------------------------------
  // External data space and on-chip expansion RAM
  // ----------------------------------------------------------------------
  localparam int          XRAM_AW       = 12;
  localparam int          XDATA_AW      = 16;
  localparam logic [15:0] XRAM_SPLIT_TOP = 16'h1000;

  typedef enum logic [1:0] {
    DMD_MAP_ONCHIP  = 2'h0,
    DMD_MAP_SPLIT   = 2'h1,
    DMD_MAP_OFFCHIP = 2'h2
  } dmd_map_t;

  // ----------------------------------------------------------------------
  // Program flash
  // ----------------------------------------------------------------------
  localparam int          SECTOR_AW      = 9;
  localparam logic [15:0] FLASH_RES_BASE = 16'hfc00;
  localparam int          SCRATCH_AW     = 7;

endpackage : dmd_pkg

`default_nettype wire

/* File: testbench/dmd_core_model.sv */
// Behavioural model of the core's memory access unit
`default_nettype none

module dmd_core_model
  import dmd_pkg::*;
(
  // Clock
  input  wire logic        clock,
  // Internal data requests
  output var  logic        idata_req,
  output var  logic [7:0]  idata_addr,
  output var  logic        idata_indirect,
  output var  logic        idata_bit,
  output var  logic [7:0]  sfr_page,
  // External data requests
  output var  logic        xdata_req,
  output var  logic        xdata_we,
  output var  logic [15:0] xdata_addr,
  output var  logic [7:0]  xdata_wdata,
  output var  logic [1:0]  map_mode,
  output var  logic        port_muxed,
  // Program requests
  output var  logic        code_req,
  output var  logic [15:0] code_addr,
  output var  logic        code_scratch,
  output var  logic        flash_64k
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    {idata_req, idata_addr, idata_indirect, idata_bit, sfr_page} = '0;
    {xdata_req, xdata_we, xdata_addr, xdata_wdata, map_mode} = '0;
    {port_muxed, code_req, code_addr, code_scratch, flash_64k} = '0;
  end

  // Addresses, page and write data are inverted once a request ends, so a late sampler
  // never sees the old value by luck.
  task automatic ireq(input logic [7:0] a, pg, input logic ind, bt);
    @(posedge clock);
    #1;
    idata_req = 1'b1;
    idata_addr = a;
    sfr_page = pg;
    idata_indirect = ind;
    idata_bit = bt;
    @(posedge clock);
    #1;
    idata_req = 1'b0;
    idata_addr = ~a;
    sfr_page = ~pg;
  endtask : ireq

  task automatic xreq(input logic we, input logic [15:0] a,
                      input logic [7:0] d, input logic [1:0] m);
    @(posedge clock);
    #1;
    xdata_req = 1'b1;
    xdata_we = we;
    xdata_addr = a;
    xdata_wdata = d;
    map_mode = m;
    port_muxed = m[0];
    @(posedge clock);
    #1;
    xdata_req = 1'b0;
    xdata_addr = ~a;
    xdata_wdata = ~d;
  endtask : xreq

  task automatic creq(input logic [15:0] a, input logic s, f);
    @(posedge clock);
    #1;
    code_req = 1'b1;
    code_addr = a;
    code_scratch = s;
    flash_64k = f;
    @(posedge clock);
    #1;
    code_req = 1'b0;
    code_addr = ~a;
  endtask : creq

endmodule : dmd_core_model

`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking testbench of the data memory address decoder
`default_nettype none

module tb_top
  import dmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock, resetn;
  logic idata_req, idata_indirect, idata_bit, xdata_req, xdata_we;
  logic port_muxed, code_req, code_scratch, flash_64k, idata_ack;
  logic iram_sel, sfr_sel, bank_hit, bit_hit, xdata_ack, xram_sel;
  logic ext_sel, offchip_memory_port_muxed, code_ack, flash_reserved;
  logic scratch_sel;
  logic [7:0]  idata_addr, sfr_page, idata_index, sfr_page_out;
  logic [7:0]  xdata_wdata, xram_rdata;
  logic [1:0]  bank_num, map_mode;
  logic [2:0]  bit_pos;
  logic [15:0] xdata_addr, code_addr, offchip_memory_port_addr;
  logic [6:0]  flash_sector, scratch_index;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;

  dmd_core_model u_dmd_core_model (.clock, .idata_req, .idata_addr,
    .idata_indirect, .idata_bit, .sfr_page, .xdata_req, .xdata_we,
    .xdata_addr, .xdata_wdata, .map_mode, .port_muxed, .code_req,
    .code_addr, .code_scratch, .flash_64k);

  dmd_decoder u_dmd_decoder (.clock, .resetn, .idata_req, .idata_addr,
    .idata_indirect, .idata_bit, .sfr_page, .idata_ack, .iram_sel,
    .sfr_sel, .idata_index, .sfr_page_out, .bank_hit, .bank_num,
    .bit_hit, .bit_pos, .xdata_req, .xdata_we, .xdata_addr, .xdata_wdata,
    .map_mode, .port_muxed, .xdata_ack, .xram_sel, .ext_sel, .xram_rdata,
    .offchip_memory_port_addr, .offchip_memory_port_muxed, .code_req,
    .code_addr, .code_scratch, .flash_64k, .code_ack, .flash_sector,
    .flash_reserved, .scratch_sel, .scratch_index);

  initial
  begin
    clock = 1'b0;
  end

  always #4 clock = ~clock;

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // Run needs under 100 cycles; a hang stops well before anything else
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic t_id(input logic [7:0] a, pg, input logic ind, bt);
    logic [7:0] idx;
    idx = bt ? (a[7] ? {a[7:3], 3'h0} : 8'h20 + {4'h0, a[6:3]}) : a;
    u_dmd_core_model.ireq(a, pg, ind, bt);
    chk(idata_ack, 1'b1);
    chk(sfr_sel, a[7] && !ind);
    chk(iram_sel, !(a[7] && !ind));
    chk(idata_index, idx);
    chk(sfr_page_out, pg);
    chk(bank_hit, !bt && a < 8'h20);
    if (!bt) chk(bank_num, a[4:3]);
    chk(bit_hit, bt && !a[7]);
    chk(bit_pos, bt ? a[2:0] : 3'h0);
  endtask : t_id

  task automatic t_idata();
    t_id(8'h85, 8'hff, 1'b0, 1'b0);
    t_id(8'h85, 8'h00, 1'b1, 1'b0);
    t_id(8'h7f, 8'h01, 1'b0, 1'b0);
    t_id(8'h7f, 8'h01, 1'b1, 1'b0);
    t_id(8'h1f, 8'h02, 1'b0, 1'b0);
    t_id(8'h20, 8'h02, 1'b0, 1'b0);
    t_id(8'h7f, 8'h03, 1'b0, 1'b1);
    t_id(8'h00, 8'h03, 1'b0, 1'b1);
    t_id(8'h83, 8'h04, 1'b0, 1'b1);
    $display("Internal data test done");
  endtask : t_idata

  task automatic t_x(input logic we, input logic [15:0] a,
                     input logic [7:0] d, input logic [1:0] m);
    logic on;
    on = m == 2'h0 || (m == 2'h1 && a < 16'h1000);
    u_dmd_core_model.xreq(we, a, d, m);
    chk(xdata_ack, 1'b1);
    chk(xram_sel, on);
    chk(ext_sel, !on);
    if (!on) chk(offchip_memory_port_addr, a);
    chk(offchip_memory_port_muxed, m[0]);
    if (on && !we) chk(xram_rdata, d);
  endtask : t_x

  task automatic t_xdata();
    t_x(1'b1, 16'h2345, 8'ha5, 2'h0);
    t_x(1'b0, 16'h0345, 8'ha5, 2'h0);
    t_x(1'b1, 16'hf0ff, 8'h3c, 2'h0);
    t_x(1'b0, 16'h00ff, 8'h3c, 2'h0);
    t_x(1'b1, 16'h0345, 8'h00, 2'h2);
    t_x(1'b0, 16'h0345, 8'ha5, 2'h1);
    t_x(1'b1, 16'h0fff, 8'h5a, 2'h1);
    t_x(1'b0, 16'h0fff, 8'h5a, 2'h1);
    t_x(1'b0, 16'h1000, 8'h00, 2'h1);
    t_x(1'b1, 16'hffff, 8'h11, 2'h3);
    $display("External data test done");
  endtask : t_xdata

  task automatic t_c(input logic [15:0] a, input logic s, f);
    u_dmd_core_model.creq(a, s, f);
    chk(code_ack, 1'b1);
    chk(flash_sector, a[15:9]);
    chk(flash_reserved, !s && f && a >= 16'hfc00);
    chk(scratch_sel, s);
    if (s) chk(scratch_index, a[6:0]);
  endtask : t_c

  task automatic t_code();
    t_c(16'hfc10, 1'b0, 1'b1);
    t_c(16'hfbff, 1'b0, 1'b1);
    t_c(16'hffff, 1'b0, 1'b1);
    t_c(16'hfc10, 1'b0, 1'b0);
    t_c(16'h00ff, 1'b1, 1'b1);
    $display("Program space test done");
  endtask : t_code

  // Mid-run reset: every registered output but xram_rdata clears, then work resumes
  task automatic t_reset();
    @(posedge clock);
    #1;
    resetn = 1'b0;
    @(posedge clock);
    #1;
    resetn = 1'b1;
    chk({idata_ack, iram_sel, sfr_sel, idata_index}, '0);
    chk({sfr_page_out, bank_hit, bank_num, bit_hit, bit_pos}, '0);
    chk({xdata_ack, xram_sel, ext_sel}, '0);
    chk({offchip_memory_port_addr, offchip_memory_port_muxed}, '0);
    chk({code_ack, flash_reserved, flash_sector}, '0);
    chk({scratch_sel, scratch_index}, '0);
    t_c(16'hfc10, 1'b0, 1'b1);
    $display("Reset test done");
  endtask : t_reset

  initial
  begin
    resetn = 1'b0;
    repeat (6) @(posedge clock);
    #1;
    resetn = 1'b1;
    t_idata();
    t_xdata();
    t_code();
    t_reset();
    stop_test();
  end

endmodule : tb_top

`default_nettype wire
